/* File: design/dcpct_top.v */
// Two channel 16-bit timer with compare outputs, input capture and reset synchronous PWM.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "dcpct_defs.vh"

// Overview of operation
// - With stop-on-match select at 0, a software write of 0 to a run bit is ignored.
// - Software stops a channel by setting stop-on-match select first and clearing run later; a write doing both at once does not stop.
// - A software stop with stop-on-match select at 1 leaves every output pin of that channel at its last level.
// - A stop at the register A match with select at 0 leaves the pins at the level that match produced.
// - A counter write that coincides with a counter clear is dropped and the counter reads zero.
// - Clear select 001 clears on A, 010 on B, 011 synchronously with the other channel, 101 on C, 110 on D.
// - Without filtering, the counter is copied two to three clocks after the capture edge at the pin.
module dcpct_top (
  input  wire        MCLK,
  input  wire        ARST_N,
  input  wire [7:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  input  wire        FOCO_TICK,
  input  wire [7:0]  TIO_IN,
  output reg  [7:0]  TIO_OUT,
  output wire [7:0]  TIO_OE,
  output wire        IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  ////////////////////////////////////////////////////////////////////////////////

  reg  [1:0]  channel_run_bit;
  reg  [1:0]  stop_on_match_select;
  reg  [1:0]  combination_mode_select;
  reg         output_level_select_0;
  reg         output_level_select_1;
  reg  [2:0]  count_source_select [0:1];
  reg  [2:0]  counter_clear_select [0:1];
  reg  [3:0]  capture_enable [0:1];
  reg  [4:0]  channel_status_reg [0:1];
  reg  [4:0]  channel_mask_reg [0:1];
  reg  [15:0] channel_counter [0:1];
  reg  [15:0] general_reg [0:7];
  reg  [2:0]  prescale;
  reg         pwm_phase;

  wire [7:0]  cap_pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  ////////////////////////////////////////////////////////////////////////////////

  wire [1:0] win = ADDR[`DCPCT_CH_SEL_MSB:`DCPCT_CH_SEL_LSB];
  wire [5:0] off = ADDR[`DCPCT_CH_SEL_LSB-1:0];
  wire [1:0] ch_hit;
  wire       start_hit = (ADDR == `DCPCT_OFS_START);
  wire       func_hit  = (ADDR == `DCPCT_OFS_FUNC);

  // One window per channel; apart from the start and function registers, anything else reads as zero and ignores writes.
  assign ch_hit[0] = (win == `DCPCT_CH0_WIN);
  assign ch_hit[1] = (win == `DCPCT_CH1_WIN);

  ////////////////////////////////////////////////////////////////////////////////
  // Capture samplers, one per timer pin.
  ////////////////////////////////////////////////////////////////////////////////

  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_cap
      dcpct_capture_sync u_cap (
        .clk       (MCLK),
        .arst_n    (ARST_N),
        .pin       (TIO_IN[k]),
        .enable    (capture_enable[k/4][k%4]),
        .cap_pulse (cap_pulse[k])
      );
    end
  endgenerate

  // A pin drives only while its general register works as a compare register.
  assign TIO_OE = ~{capture_enable[1], capture_enable[0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Count ticks, compare matches and clear sources.
  ////////////////////////////////////////////////////////////////////////////////

  reg  [1:0] tick;
  reg  [7:0] match;
  reg  [1:0] own_clr;
  reg  [1:0] clr;
  reg  [1:0] ovf;
  reg  [1:0] cnt_wr;
  reg        rspwm;
  reg        next_pwm_phase;
  integer    c;
  integer    j;

  // Tick, match, clear and overflow for both channels in the current cycle.
  always @* begin
    tick           = 2'h0;
    match          = 8'h00;
    own_clr        = 2'h0;
    clr            = 2'h0;
    ovf            = 2'h0;
    cnt_wr         = 2'h0;
    rspwm          = (combination_mode_select == `DCPCT_CMD_RSPWM);
    next_pwm_phase = pwm_phase;
    for (c = 0; c < 2; c = c + 1) begin
      case (count_source_select[c])
        `DCPCT_SRC_F1:   tick[c] = channel_run_bit[c];
        `DCPCT_SRC_DIV2: tick[c] = channel_run_bit[c] & prescale[0];
        `DCPCT_SRC_DIV4: tick[c] = channel_run_bit[c] & (&prescale[1:0]);
        `DCPCT_SRC_DIV8: tick[c] = channel_run_bit[c] & (&prescale);
        `DCPCT_SRC_FOCO: tick[c] = channel_run_bit[c] & FOCO_TICK;
        default:         tick[c] = 1'b0;
      endcase
      for (j = 0; j < 4; j = j + 1) begin
        match[c*4+j] = tick[c] & ~capture_enable[c][j]
                       & (channel_counter[c] == general_reg[c*4+j]);
      end
      case (counter_clear_select[c])
        `DCPCT_CLR_A: own_clr[c] = match[c*4];
        `DCPCT_CLR_B: own_clr[c] = match[c*4+1];
        `DCPCT_CLR_C: own_clr[c] = match[c*4+2];
        `DCPCT_CLR_D: own_clr[c] = match[c*4+3];
        default:      own_clr[c] = 1'b0;
      endcase
      cnt_wr[c] = WR & ch_hit[c] & (off == `DCPCT_OFS_CNT);
    end
    // Reset synchronous PWM ties the channel 0 period to register A.
    if (rspwm) begin
      own_clr[0] = own_clr[0] | match[0];
    end
    // Synchronous clear follows the other channel's own clear source.
    for (c = 0; c < 2; c = c + 1) begin
      clr[c] = own_clr[c]
               | ((counter_clear_select[c] == `DCPCT_CLR_SYNC) & own_clr[1-c]);
      ovf[c] = tick[c] & ~clr[c] & (channel_counter[c] == `DCPCT_CNT_MAX);
    end
    // The PWM phase opens at the period start and closes at the register B match.
    if (match[0]) begin
      next_pwm_phase = 1'b1;
    end else if (match[1]) begin
      next_pwm_phase = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers, counters and pins.
  ////////////////////////////////////////////////////////////////////////////////

  // Main sequential process; clears, captures and new status events win over software writes of the same cycle, but counting and match stops lose to them.
  always @(posedge MCLK or negedge ARST_N) begin : p_main
    integer c;
    integer j;
    if (!ARST_N) begin
      channel_run_bit         <= 2'h0;
      stop_on_match_select    <= 2'h0;
      combination_mode_select <= `DCPCT_CMD_TIMER;
      output_level_select_0   <= 1'b0;
      output_level_select_1   <= 1'b0;
      prescale                <= 3'h0;
      pwm_phase               <= 1'b0;
      TIO_OUT                 <= 8'h00;
      for (c = 0; c < 2; c = c + 1) begin
        count_source_select[c]  <= `DCPCT_SRC_F1;
        counter_clear_select[c] <= 3'h0;
        capture_enable[c]       <= 4'h0;
        channel_status_reg[c]   <= 5'h00;
        channel_mask_reg[c]     <= 5'h00;
        channel_counter[c]      <= `DCPCT_CNT_RST;
      end
      for (c = 0; c < 8; c = c + 1) begin
        general_reg[c] <= `DCPCT_GR_RST;
      end
    end else begin
      prescale  <= prescale + 3'h1;
      pwm_phase <= next_pwm_phase;
      if (WR && func_hit) begin
        combination_mode_select <= WDATA[`DCPCT_CMD_MSB:`DCPCT_CMD_LSB];
        output_level_select_0   <= WDATA[`DCPCT_OUTPUT_LEVEL_SELECT_0_BIT];
        output_level_select_1   <= WDATA[`DCPCT_OUTPUT_LEVEL_SELECT_1_BIT];
      end
      for (c = 0; c < 2; c = c + 1) begin
        // Run bit: a register A match stops the channel when select is 0.
        if (!stop_on_match_select[c] && match[c*4]) begin
          channel_run_bit[c] <= 1'b0;
        end
        if (WR && start_hit) begin
          stop_on_match_select[c] <= WDATA[`DCPCT_CSEL_LSB+c];
          if (WDATA[`DCPCT_RUN_LSB+c]) begin
            channel_run_bit[c] <= 1'b1;
          end else if (stop_on_match_select[c]) begin
            // The stop sees the select value from before this write.
            channel_run_bit[c] <= 1'b0;
          end
        end
        // Channel control and I/O selection.
        if (WR && ch_hit[c] && off == `DCPCT_OFS_CTL) begin
          count_source_select[c]  <= WDATA[`DCPCT_SRC_MSB:`DCPCT_SRC_LSB];
          counter_clear_select[c] <= WDATA[`DCPCT_CLR_MSB:`DCPCT_CLR_LSB];
        end
        if (WR && ch_hit[c] && off == `DCPCT_OFS_IOSEL) begin
          capture_enable[c] <= WDATA[3:0];
        end
        if (WR && ch_hit[c] && off == `DCPCT_OFS_MASK) begin
          channel_mask_reg[c] <= WDATA[`DCPCT_STAT_W-1:0];
        end
        // Counter: clear beats a software write, which beats counting.
        if (clr[c]) begin
          channel_counter[c] <= `DCPCT_ZERO16;
        end else if (cnt_wr[c]) begin
          channel_counter[c] <= WDATA;
        end else if (tick[c]) begin
          channel_counter[c] <= channel_counter[c] + 16'h0001;
        end
        // Status flags are sticky, cleared by writing one; a new event wins.
        if (WR && ch_hit[c] && off == `DCPCT_OFS_STAT) begin
          channel_status_reg[c] <= (channel_status_reg[c] & ~WDATA[`DCPCT_STAT_W-1:0])
                                   | {ovf[c], match[c*4 +: 4] | cap_pulse[c*4 +: 4]};
        end else begin
          channel_status_reg[c] <= channel_status_reg[c]
                                   | {ovf[c], match[c*4 +: 4] | cap_pulse[c*4 +: 4]};
        end
        // General registers: a capture copy beats a software write.
        for (j = 0; j < 4; j = j + 1) begin
          if (cap_pulse[c*4+j]) begin
            general_reg[c*4+j] <= channel_counter[c];
          end else if (WR && ch_hit[c] && off == `DCPCT_OFS_GRA + 6'h04 * j[5:0]) begin
            general_reg[c*4+j] <= WDATA;
          end
        end
        // Pins change only on a match, or for pins 1 and 3 in reset synchronous PWM on an output level write, so any stop freezes them where they were.
        for (j = 0; j < 4; j = j + 1) begin
          if (rspwm && c == 0 && j == 1) begin
            TIO_OUT[1] <= next_pwm_phase ^ output_level_select_1;
          end else if (rspwm && c == 0 && j == 3) begin
            TIO_OUT[3] <= ~next_pwm_phase ^ output_level_select_0;
          end else if (match[c*4+j]) begin
            TIO_OUT[c*4+j] <= ~TIO_OUT[c*4+j];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path and interrupt.
  ////////////////////////////////////////////////////////////////////////////////

  reg [15:0] next_rdata;
  reg [1:0]  rsel;

  // Read multiplexer; unmapped addresses return zero.
  always @* begin : p_rmux
    integer c;
    c          = 0;
    next_rdata = `DCPCT_ZERO16;
    rsel       = ch_hit;
    if (start_hit) begin
      next_rdata = {12'h000, stop_on_match_select, channel_run_bit};
    end else if (func_hit) begin
      next_rdata = {10'h000, output_level_select_1, output_level_select_0,
                    2'h0, combination_mode_select};
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        if (rsel[c]) begin
          case (off)
            `DCPCT_OFS_CTL:   next_rdata = {10'h000, counter_clear_select[c],
                                            count_source_select[c]};
            `DCPCT_OFS_IOSEL: next_rdata = {12'h000, capture_enable[c]};
            `DCPCT_OFS_STAT:  next_rdata = {11'h000, channel_status_reg[c]};
            `DCPCT_OFS_MASK:  next_rdata = {11'h000, channel_mask_reg[c]};
            `DCPCT_OFS_CNT:   next_rdata = channel_counter[c];
            `DCPCT_OFS_GRA:   next_rdata = general_reg[c*4];
            `DCPCT_OFS_GRB:   next_rdata = general_reg[c*4+1];
            `DCPCT_OFS_GRC:   next_rdata = general_reg[c*4+2];
            `DCPCT_OFS_GRD:   next_rdata = general_reg[c*4+3];
            default:          next_rdata = `DCPCT_ZERO16;
          endcase
        end
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= `DCPCT_ZERO16;
    end else begin
      RDATA <= RD ? next_rdata : `DCPCT_ZERO16;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign IRQ = |((channel_status_reg[0] & channel_mask_reg[0])
               | (channel_status_reg[1] & channel_mask_reg[1]));

endmodule // dcpct_top

/* File: common/dcpct_defs.vh */
// Shared constants for the dual channel PWM and capture timer.
`ifndef DCPCT_DEFS_VH
`define DCPCT_DEFS_VH

// Shared registers at fixed byte addresses.
`define DCPCT_OFS_START     8'h00
`define DCPCT_OFS_FUNC      8'h04

// Channel windows are selected by address bits 7:6.
`define DCPCT_CH_SEL_MSB    7
`define DCPCT_CH_SEL_LSB    6
`define DCPCT_CH0_WIN       2'h1
`define DCPCT_CH1_WIN       2'h2

// Offsets inside one channel window.
`define DCPCT_OFS_CTL       6'h00
`define DCPCT_OFS_IOSEL     6'h04
`define DCPCT_OFS_STAT      6'h08
`define DCPCT_OFS_MASK      6'h0C
`define DCPCT_OFS_CNT       6'h10
`define DCPCT_OFS_GRA       6'h14
`define DCPCT_OFS_GRB       6'h18
`define DCPCT_OFS_GRC       6'h1C
`define DCPCT_OFS_GRD       6'h20

// Start control register fields.
`define DCPCT_RUN_LSB       0
`define DCPCT_CSEL_LSB      2

// Function control register fields.
`define DCPCT_CMD_MSB       1
`define DCPCT_CMD_LSB       0
`define DCPCT_OUTPUT_LEVEL_SELECT_0_BIT      4
`define DCPCT_OUTPUT_LEVEL_SELECT_1_BIT      5
`define DCPCT_CMD_TIMER     2'h0
`define DCPCT_CMD_RSPWM     2'h1

// Channel control register fields.
`define DCPCT_SRC_MSB       2
`define DCPCT_SRC_LSB       0
`define DCPCT_CLR_MSB       5
`define DCPCT_CLR_LSB       3

// Count source codes.
`define DCPCT_SRC_F1        3'h0
`define DCPCT_SRC_DIV2      3'h1
`define DCPCT_SRC_DIV4      3'h2
`define DCPCT_SRC_DIV8      3'h3
`define DCPCT_SRC_FOCO      3'h6

// Counter clear codes.
`define DCPCT_CLR_A         3'h1
`define DCPCT_CLR_B         3'h2
`define DCPCT_CLR_SYNC      3'h3
`define DCPCT_CLR_C         3'h5
`define DCPCT_CLR_D         3'h6

// Status layout: bits 3:0 compare or capture on A..D, bit 4 overflow.
`define DCPCT_STAT_W        5
`define DCPCT_OVF_BIT       4

// Reset values, counter maximum and zero.
`define DCPCT_CNT_RST       16'h0000
`define DCPCT_GR_RST        16'hFFFF
`define DCPCT_CNT_MAX       16'hFFFF
`define DCPCT_ZERO16        16'h0000

`endif

/* File: design/dcpct_capture_sync.v */
// Capture input sampler with rising edge detect for one timer pin.
`timescale 1ns/1ps
module dcpct_capture_sync (
  input  wire clk,
  input  wire arst_n,
  input  wire pin,
  input  wire enable,
  output wire cap_pulse
);

  reg s1;
  reg s2;
  reg s3;

  // Three stage shift; only the second and third stages feed the edge detect.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // One cycle pulse on a rising edge, so the copy lands two to three cycles after the pin.
  assign cap_pulse = enable & s2 & ~s3;

endmodule // dcpct_capture_sync

/* File: testbench/dcpct_top_asserts.sv */
// Port-level assertions for the dual channel timer, with their bind.
`timescale 1ns/1ps
module dcpct_chk (
  input wire        MCLK,
  input wire        ARST_N,
  input wire [7:0]  ADDR,
  input wire [15:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [15:0] RDATA,
  input wire [7:0]  TIO_IN,
  input wire [7:0]  TIO_OUT,
  input wire [7:0]  TIO_OE,
  input wire        IRQ
);
  logic       cs0;
  logic       run0;
  logic [4:0] mk0;
  logic [4:0] mk1;
  logic       st;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////
  // Software view of stop select, run request and masks, rebuilt from writes.
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs0  <= 1'b0;
      run0 <= 1'b0;
      mk0  <= 5'h00;
      mk1  <= 5'h00;
    end else if (WR) begin
      if (ADDR == 8'h00) begin
        cs0  <= WDATA[2];
        run0 <= WDATA[0] | (run0 & ~cs0);
      end
      if (ADDR == 8'h4C) mk0 <= WDATA[4:0];
      if (ADDR == 8'h8C) mk1 <= WDATA[4:0];
    end
  end
  // A start write that clears run while stop select is already set.
  assign st = WR && ADDR == 8'h00 && !WDATA[0] && cs0;
  ////////////////////////////////////////
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside a read answer");
  chk_unmapped_zero: assert property (RD && ADDR == 8'hFC |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (mk0 == 5'h00 && mk1 == 5'h00 |-> !IRQ)
    else $error("interrupt high with all masks clear");
  chk_run_kept: assert property (WR && ADDR == 8'h00 && WDATA[2:0] == 3'h0
    && !cs0 && run0 ##1 RD && ADDR == 8'h00 |=> RDATA[0])
    else $error("run bit dropped while stop select was clear");
  chk_joint_write: assert property (WR && ADDR == 8'h00 && WDATA[2:0] == 3'h4
    && !cs0 && run0 ##1 RD && ADDR == 8'h00 |=> RDATA[0])
    else $error("joint select and stop write stopped the count");
  chk_stop_hold: assert property (st |=> ##1 $stable(TIO_OUT[3:0]) [*4])
    else $error("pins moved after a software stop");
  chk_match_hold: assert property ($changed(TIO_OUT[0]) && TIO_OE[0] && !cs0
    |=> $stable(TIO_OUT[3:0]) [*4])
    else $error("pins moved after a stop at match");
  chk_capture_lag: assert property ($rose(TIO_IN[0]) && !TIO_OE[0] && mk0[0] && !IRQ
    |=> !IRQ ##1 !IRQ ##[1:2] IRQ)
    else $error("capture flag not set two to three clocks after the edge");
endmodule // dcpct_chk

bind dcpct_top dcpct_chk u_chk (
  .MCLK    (MCLK),
  .ARST_N  (ARST_N),
  .ADDR    (ADDR),
  .WDATA   (WDATA),
  .WR      (WR),
  .RD      (RD),
  .RDATA   (RDATA),
  .TIO_IN  (TIO_IN),
  .TIO_OUT (TIO_OUT),
  .TIO_OE  (TIO_OE),
  .IRQ     (IRQ)
);

/* File: testbench/dcpct_pin_model.sv */
// Capture signal source standing on the far side of the timer pins.
`timescale 1ns/1ps
module dcpct_pin_model #(
  parameter int PIN = 0
) (
  input  wire        clk,
  input  wire        fire,
  output logic [7:0] pins
);
  logic [1:0] left;
  // Pins idle low from time zero.
  initial begin
    pins = 8'h00;
    left = 2'h0;
  end
  // A request holds the pin high for three clocks so the sampler cannot miss it.
  always @(posedge clk) begin
    if (fire) begin
      pins[PIN] <= 1'b1;
      left      <= 2'h2;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end else begin
      pins <= 8'h00;
    end
  end
endmodule // dcpct_pin_model

/* File: testbench/dcpct_top_tb.sv */
// Self-checking bench for the dual channel timer.
`timescale 1ns/1ps
module dcpct_top_tb;
  logic        MCLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        FOCO_TICK = 1'b0;
  logic        fire = 1'b0;
  wire  [15:0] RDATA;
  wire  [7:0]  TIO_IN;
  wire  [7:0]  TIO_OUT;
  wire  [7:0]  TIO_OE;
  wire         IRQ;
  int          errors = 0;
  int          samples_checked = 0;
  int          hits;
  logic [15:0] d;
  logic [15:0] prev;
  logic [7:0]  p;
  logic        q;
  logic        pin0;
  logic [3:0]  pins_before;
  logic [40:0] rows [5];
  logic [15:0] codes [5];
  ////////////////////////////////////////
  // Clock and a fast source tick on every other edge.
  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) FOCO_TICK <= ~FOCO_TICK;
  dcpct_top u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .FOCO_TICK(FOCO_TICK), .TIO_IN(TIO_IN), .TIO_OUT(TIO_OUT),
    .TIO_OE(TIO_OE), .IRQ(IRQ));
  dcpct_pin_model #(.PIN(0)) u_pins (.clk(MCLK), .fire(fire), .pins(TIO_IN));
  ////////////////////////////////////////
  // Compares one value and reports a difference.
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus write; the strobe stays up until the next task drives it.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    RD    <= 1'b0;
    @(posedge MCLK);
  endtask
  // Bus read; data, interrupt and pins are taken mid-cycle where settled.
  task automatic rd(input logic [7:0] a);
    ADDR <= a;
    WR   <= 1'b0;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    d = RDATA;
    q = IRQ;
    p = TIO_OUT;
    @(posedge MCLK);
  endtask
  // Idle cycles.
  task automatic nop(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge MCLK);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog far beyond the expected run length.
  initial begin
    #1_000_000;
    errors++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    rows = '{{1'b0, 8'h54, 16'h0000, 16'hFFFF}, {1'b0, 8'h50, 16'h0000, 16'h0000},
      {1'b0, 8'h00, 16'h0000, 16'h0000}, {1'b1, 8'hFC, 16'h1234, 16'h0000},
      {1'b1, 8'h98, 16'hA5A5, 16'hA5A5}};
    codes = '{16'h110A, 16'h2314, 16'h571E, 16'h6F28, 16'h310F};
    repeat (16) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    foreach (rows[i]) begin
      if (rows[i][40]) wr(rows[i][39:32], rows[i][31:16]);
      rd(rows[i][39:32]);
      chk("register", d, rows[i][15:0]);
    end
    $display("test rows done");
    for (int j = 0; j < 4; j++) wr(8'h54 + 8'(4 * j), 16'(10 * j + 10));
    wr(8'h94, 16'h000F);
    wr(8'h80, 16'h0008);
    foreach (codes[i]) begin
      wr(8'h40, {10'h000, codes[i][14:12], 3'h0});
      wr(8'h48, 16'h001F);
      wr(8'h50, 16'h0000);
      wr(8'h00, 16'h000F);
      nop(200);
      wr(8'h00, 16'h000C);
      rd(8'h48);
      chk("clear flags", d, {12'h000, codes[i][11:8]});
      rd(8'h50);
      chk("clear bound", 16'(d <= {8'h00, codes[i][7:0]}), 16'h0001);
    end
    $display("test clear codes done");
    wr(8'h40, 16'h0000);
    wr(8'h54, 16'hFFFF);
    wr(8'h50, 16'h0000);
    wr(8'h00, 16'h0001);
    wr(8'h00, 16'h0000);
    rd(8'h00);
    chk("run kept", d, 16'h0001);
    wr(8'h00, 16'h0004);
    rd(8'h00);
    chk("joint write", d, 16'h0005);
    wr(8'h00, 16'h0004);
    rd(8'h00);
    chk("stopped", d, 16'h0004);
    rd(8'h50);
    prev = d;
    pin0 = p[0];
    pins_before = p[3:0];
    nop(5);
    rd(8'h50);
    chk("count frozen", d, prev);
    chk("pins held", {12'h000, p[3:0]}, {12'h000, pins_before});
    $display("test stop control done");
    wr(8'h54, 16'h001E);
    wr(8'h40, 16'h0008);
    wr(8'h00, 16'h0001);
    nop(60);
    rd(8'h00);
    chk("match stop", d, 16'h0000);
    rd(8'h50);
    chk("match clear", d, 16'h0000);
    chk("match level", {15'h0000, p[0]}, {15'h0000, ~pin0});
    $display("test match stop done");
    wr(8'h54, 16'h0004);
    hits = 0;
    for (int k = 0; k < 5; k++) begin
      wr(8'h50, 16'h0000);
      wr(8'h00, 16'h0005);
      nop(k + 1);
      wr(8'h50, 16'h0100);
      wr(8'h00, 16'h0004);
      rd(8'h50);
      if (d <= 16'h0004) hits++;
      nop(3);
    end
    chk("dropped writes", 16'(hits), 16'h0001);
    $display("test write collision done");
    wr(8'h44, 16'h0001);
    wr(8'h50, 16'h1234);
    wr(8'h48, 16'h001F);
    wr(8'h4C, 16'h0001);
    fire <= 1'b1;
    nop(1);
    fire <= 1'b0;
    nop(6);
    rd(8'h54);
    chk("captured", d, 16'h1234);
    chk("irq raised", {15'h0000, q}, 16'h0001);
    wr(8'h4C, 16'h0000);
    rd(8'hFC);
    chk("irq masked", {15'h0000, q}, 16'h0000);
    wr(8'h4C, 16'h0001);
    wr(8'h48, 16'h0001);
    rd(8'h48);
    chk("irq cleared", {15'h0000, q}, 16'h0000);
    $display("test capture done");
    wr(8'h40, 16'h0006);
    wr(8'h50, 16'h0000);
    wr(8'h00, 16'h0005);
    nop(20);
    wr(8'h00, 16'h0004);
    rd(8'h50);
    chk("fast source", 16'(d >= 16'h000A && d <= 16'h000B), 16'h0001);
    wr(8'h40, 16'h0003);
    nop(2);
    wr(8'h50, 16'h0000);
    wr(8'h00, 16'h0005);
    nop(20);
    wr(8'h00, 16'h0004);
    rd(8'h50);
    chk("divide by eight", 16'(d >= 16'h0002 && d <= 16'h0003), 16'h0001);
    $display("test count sources done");
    ARST_N <= 1'b0;
    nop(2);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    rd(8'h54);
    chk("reset gra", d, 16'hFFFF);
    chk("reset pins", {p, TIO_OE}, 16'h00FF);
    $display("test reset done");
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0000);
    wr(8'h04, 16'h0031);
    rd(8'h04);
    chk("pwm mode", d, 16'h0031);
    chk("pwm pins", {14'h0000, p[3], p[1]}, 16'h0001);
    $display("test pwm done");
    give_verdict();
  end
endmodule // dcpct_top_tb
